/* File: fifo_defines.svh */
// constants for the sampled-clock 511 x 36 fifo and its register port
`ifndef FIFO_DEFINES_SVH
`define FIFO_DEFINES_SVH

`define FIFO_AW          9
`define FIFO_DW          36
`define FIFO_LEVEL_MSB   8
`define FIFO_LEVEL_LSB   5
`define PTR_ZERO         9'h000
`define RD_NEXT_RST      9'h001
`define RD_LAST_RST      9'h100
`define WR_NEXT_RST      9'h001

`define REG_AW           8
`define REG_DW           32
`define REG_STATUS       8'h00
`define REG_MASK         8'h04
`define REG_STATE        8'h08
`define EV_W             4
`define EV_OVERFLOW      0
`define EV_UNDERFLOW     1
`define EV_FULL          2
`define EV_EMPTY         3
`define ST_EMPTY         0
`define ST_FULL          1
`define ST_LEVEL_LSB     4

`endif

/* File: fifo_pkg.sv */
// types and the gray conversion shared by the fifo files
`include "fifo_defines.svh"
package fifo_pkg;
    typedef logic [`FIFO_AW-1:0] ptr_type;   // binary or gray pointer
    typedef logic [`FIFO_DW-1:0] word_type;  // one stored word
    typedef logic [`EV_W-1:0]    ev_type;    // event bit set

    // binary to gray: one bit changes per increment
    function automatic ptr_type gray_of(input ptr_type bin);
        gray_of = bin ^ (bin >> 1);
    endfunction : gray_of
endpackage : fifo_pkg

/* File: fifo_ram.sv */
// simple dual-port storage with a registered read port
`timescale 1ns/100ps
`include "fifo_defines.svh"
module fifo_ram (
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    input  wire logic              wr_en_i,
    input  wire fifo_pkg::ptr_type wr_addr_i,
    input  wire fifo_pkg::word_type wr_data_i,
    input  wire logic              rd_en_i,
    input  wire fifo_pkg::ptr_type rd_addr_i,
    output fifo_pkg::word_type     rd_data_o
);
    // full 512-entry array; one entry always stays unused
    fifo_pkg::word_type mem [0:(1<<`FIFO_AW)-1];
    fifo_pkg::word_type rd_data_ff;   // read port register

    // storage write, no reset so it maps to block memory
    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // read register holds its word until the next read
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_ff <= '0;
        end else if (rd_en_i) begin
            rd_data_ff <= mem[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_ff;
endmodule : fifo_ram

/* File: dual_clock_fifo.sv */
// 511 x 36 fifo whose write and read clocks are sampled by clock_i
`timescale 1ns/100ps
`include "fifo_defines.svh"
module dual_clock_fifo (
    input  wire logic                clock_i,
    input  wire logic                nrst_i,
    // write side, all pins from the writer's clock domain
    input  wire logic                wr_clk_i,
    input  wire logic                wr_en_i,
    input  wire fifo_pkg::word_type  wr_data_i,
    output logic                     wr_full_o,
    // read side, pins from the reader's clock domain except fill_level_o, which moves on the write tick
    input  wire logic                rd_clk_i,
    input  wire logic                rd_en_i,
    output fifo_pkg::word_type       rd_data_o,
    output logic                     rd_empty_o,
    output logic [3:0]               fill_level_o,
    // register port
    input  wire logic [`REG_AW-1:0]  reg_addr_i,
    input  wire logic [`REG_DW-1:0]  reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic [`REG_DW-1:0]       reg_rdata_o,
    output logic                     irq_o
);
    // pin synchronisers: s1 feeds only s2; s3 is the value one sample earlier
    logic                wclk_s1_ff, wclk_s2_ff, wclk_s3_ff;
    logic                rclk_s1_ff, rclk_s2_ff, rclk_s3_ff;
    logic                wen_s1_ff,  wen_s2_ff,  wen_s3_ff;
    logic                ren_s1_ff,  ren_s2_ff,  ren_s3_ff;
    fifo_pkg::word_type  wdat_s1_ff, wdat_s2_ff, wdat_s3_ff;

    // write side state
    fifo_pkg::ptr_type   wbin_ff;     // write address counter
    fifo_pkg::ptr_type   wgray_ff;    // gray of wbin_ff
    fifo_pkg::ptr_type   wnext_ff;    // gray of wbin_ff + 1
    logic                full_ff;     // full flag, write side
    fifo_pkg::ptr_type   rsamp_ff;    // read counter seen by write side
    logic [3:0]          level_ff;    // fill level in sixteenths

    // read side state
    fifo_pkg::ptr_type   rbin_ff;     // read address counter
    fifo_pkg::ptr_type   rgray_ff;    // gray of rbin_ff
    fifo_pkg::ptr_type   rnext_ff;    // gray of rbin_ff + 1
    fifo_pkg::ptr_type   rlast_ff;    // gray of rbin_ff - 1
    logic                empty_ff;    // empty flag, read side

    // register file
    fifo_pkg::ev_type    status_ff;   // sticky events
    fifo_pkg::ev_type    mask_ff;     // interrupt enables
    logic [`REG_DW-1:0]  rdata_ff;    // read data, one cycle only
    logic                irq_ff;      // interrupt level

    // synchronise every link pin through two flops before use
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {wclk_s1_ff, wclk_s2_ff, wclk_s3_ff} <= 3'h0;
            {rclk_s1_ff, rclk_s2_ff, rclk_s3_ff} <= 3'h0;
            {wen_s1_ff,  wen_s2_ff,  wen_s3_ff}  <= 3'h0;
            {ren_s1_ff,  ren_s2_ff,  ren_s3_ff}  <= 3'h0;
            wdat_s1_ff <= '0;
            wdat_s2_ff <= '0;
            wdat_s3_ff <= '0;
        end else begin
            {wclk_s3_ff, wclk_s2_ff, wclk_s1_ff} <= {wclk_s2_ff, wclk_s1_ff, wr_clk_i};
            {rclk_s3_ff, rclk_s2_ff, rclk_s1_ff} <= {rclk_s2_ff, rclk_s1_ff, rd_clk_i};
            {wen_s3_ff,  wen_s2_ff,  wen_s1_ff}  <= {wen_s2_ff,  wen_s1_ff,  wr_en_i};
            {ren_s3_ff,  ren_s2_ff,  ren_s1_ff}  <= {ren_s2_ff,  ren_s1_ff,  rd_en_i};
            wdat_s3_ff <= wdat_s2_ff;
            wdat_s2_ff <= wdat_s1_ff;
            wdat_s1_ff <= wr_data_i;
        end
    end

    // one-cycle ticks at each link clock rising edge; the side logic
    // below advances only on its own tick, so the two sides stay
    // independent in rate and phase
    wire wr_tick = wclk_s2_ff & ~wclk_s3_ff;
    wire rd_tick = rclk_s2_ff & ~rclk_s3_ff;

    // enables and data use s3: the sample taken before the edge was
    // seen, so a writer changing data right after its edge is safe
    wire write_allow = wr_tick & wen_s3_ff & ~full_ff;
    wire read_allow  = rd_tick & ren_s3_ff & ~empty_ff;

    // counters advance by one, gray pointers step along with them
    wire fifo_pkg::ptr_type wbin_inc  = fifo_pkg::ptr_type'(wbin_ff + 1'b1);
    wire fifo_pkg::ptr_type wbin_inc2 = fifo_pkg::ptr_type'(wbin_ff + 2'd2);
    wire fifo_pkg::ptr_type rbin_inc  = fifo_pkg::ptr_type'(rbin_ff + 1'b1);
    wire fifo_pkg::ptr_type rbin_inc2 = fifo_pkg::ptr_type'(rbin_ff + 2'd2);
    // one behind the read counter, only used to check the last-read pointer
    wire fifo_pkg::ptr_type rbin_dec  = fifo_pkg::ptr_type'(rbin_ff - 1'b1);

    // flag decode: the early term catches the final operation
    wire nxt_empty = (rgray_ff == wgray_ff)
                   | (read_allow & (rnext_ff == wgray_ff));
    wire nxt_full  = (wgray_ff == rlast_ff)
                   | (write_allow & (wnext_ff == rlast_ff));

    // write counter and write gray pointers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wbin_ff  <= `PTR_ZERO;
            wgray_ff <= `PTR_ZERO;
            wnext_ff <= `WR_NEXT_RST;
        end else if (write_allow) begin
            wbin_ff  <= wbin_inc;
            wgray_ff <= wnext_ff;
            wnext_ff <= fifo_pkg::gray_of(wbin_inc2);
        end
    end

    // full flag lives on the write tick; reset forces it high
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            full_ff <= 1'b1;
        end else if (wr_tick) begin
            full_ff <= nxt_full;
        end
    end

    // read counter and read gray pointers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rbin_ff  <= `PTR_ZERO;
            rgray_ff <= `PTR_ZERO;
            rnext_ff <= `RD_NEXT_RST;
            rlast_ff <= `RD_LAST_RST;
        end else if (read_allow) begin
            rbin_ff  <= rbin_inc;
            rlast_ff <= rgray_ff;
            rgray_ff <= rnext_ff;
            rnext_ff <= fifo_pkg::gray_of(rbin_inc2);
        end
    end

    // empty flag lives on the read tick; it clears on the first tick
    // that sees the moved write pointer
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            empty_ff <= 1'b1;
        end else if (rd_tick) begin
            empty_ff <= nxt_empty;
        end
    end

    // fill level: the read counter is sampled on a write tick, so a
    // write shows one tick later and a read two; drop this block to
    // save logic when the level is not wanted
    wire fifo_pkg::ptr_type used = fifo_pkg::ptr_type'(wbin_ff - rsamp_ff);
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsamp_ff <= `PTR_ZERO;
            level_ff <= 4'h0;
        end else if (wr_tick) begin
            rsamp_ff <= rbin_ff;
            level_ff <= used[`FIFO_LEVEL_MSB:`FIFO_LEVEL_LSB];
        end
    end

    // storage: write port on write_allow, read port on read_allow
    fifo_ram i_fifo_ram (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .wr_en_i   (write_allow),
        .wr_addr_i (wbin_ff),
        .wr_data_i (wdat_s3_ff),
        .rd_en_i   (read_allow),
        .rd_addr_i (rbin_ff),
        .rd_data_o (rd_data_o)
    );

    // events: refused accesses and flags reaching their active state
    fifo_pkg::ev_type events;
    assign events[`EV_OVERFLOW]  = wr_tick & wen_s3_ff & full_ff;
    assign events[`EV_UNDERFLOW] = rd_tick & ren_s3_ff & empty_ff;
    assign events[`EV_FULL]      = wr_tick & nxt_full & ~full_ff;
    assign events[`EV_EMPTY]     = rd_tick & nxt_empty & ~empty_ff;

    // register decode
    wire sel_status = (reg_addr_i == `REG_STATUS);
    wire sel_mask   = (reg_addr_i == `REG_MASK);
    wire sel_state  = (reg_addr_i == `REG_STATE);
    wire fifo_pkg::ev_type w1c = (reg_wr_i & sel_status) ? reg_wdata_i[`EV_W-1:0] : '0;
    // a new event wins over a write-one clear in the same cycle
    wire fifo_pkg::ev_type nxt_status = (status_ff & ~w1c) | events;
    wire [`REG_DW-1:0] state_word = {{(`REG_DW-`ST_LEVEL_LSB-4){1'b0}}, level_ff,
                                     2'b00, full_ff, empty_ff};
    logic [`REG_DW-1:0] rd_mux;
    always_comb begin
        if (sel_status) begin
            rd_mux = {{(`REG_DW-`EV_W){1'b0}}, status_ff};
        end else if (sel_mask) begin
            rd_mux = {{(`REG_DW-`EV_W){1'b0}}, mask_ff};
        end else if (sel_state) begin
            rd_mux = state_word;
        end else begin
            rd_mux = '0;           // unmapped reads return zero
        end
    end

    // status, mask, read data and interrupt registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_ff <= '0;
            mask_ff   <= '0;
            rdata_ff  <= '0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (reg_wr_i && sel_mask) begin
                mask_ff <= reg_wdata_i[`EV_W-1:0];
            end
            rdata_ff <= reg_rd_i ? rd_mux : '0;
            irq_ff   <= |(nxt_status & (reg_wr_i && sel_mask ?
                                        reg_wdata_i[`EV_W-1:0] : mask_ff));
        end
    end

    assign wr_full_o    = full_ff;
    assign rd_empty_o   = empty_ff;
    assign fill_level_o = level_ff;
    assign reg_rdata_o  = rdata_ff;
    assign irq_o        = irq_ff;

    // checks
    a_write_refused: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_tick && wen_s3_ff && full_ff |=> $stable(wbin_ff))
        else $error("write advanced while full");
    a_read_refused: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_tick && ren_s3_ff && empty_ff |=> $stable(rbin_ff) && $stable(rgray_ff))
        else $error("read advanced while empty");
    a_empty_equal: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_tick && (rgray_ff == wgray_ff) |=> empty_ff)
        else $error("empty low with equal pointers");
    a_full_equal: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_tick && (wgray_ff == rlast_ff) |=> full_ff)
        else $error("full low with 511 words held");
    a_empty_early: assert property (@(posedge clock_i) disable iff (!nrst_i)
        read_allow && (rbin_inc == wbin_ff) |=> empty_ff)
        else $error("empty late after final read");
    a_empty_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_tick && (rbin_ff != wbin_ff) && !(read_allow && rbin_inc == wbin_ff)
        |=> !empty_ff)
        else $error("empty held with data present");
    a_full_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_tick && (wbin_inc != rbin_ff) && !(write_allow && wbin_inc2 == rbin_ff)
        |=> !full_ff)
        else $error("full held with room present");
    a_gray_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $changed(wgray_ff) |-> $onehot(wgray_ff ^ $past(wgray_ff)))
        else $error("write gray changed more than one bit");
    a_full_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !wr_tick |=> $stable(full_ff))
        else $error("full changed off the write tick");
    a_level_empty: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_tick && (wbin_ff == rsamp_ff) |=> (level_ff == 4'h0))
        else $error("level nonzero with nothing stored");

    // pointer coding is checked at every edge, not only after moves, so a
    // corrupted pipeline stage shows up even while both sides sit idle

    // empty may move only on a read tick
    a_empty_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !rd_tick |=> $stable(empty_ff))
        else $error("empty changed off the read tick");

    // read gray pointer steps one bit at a time
    a_rgray_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $changed(rgray_ff) |-> $onehot(rgray_ff ^ $past(rgray_ff)))
        else $error("read gray changed more than one bit");

    // last-read pointer follows the same one-bit steps
    a_rlast_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $changed(rlast_ff) |-> $onehot(rlast_ff ^ $past(rlast_ff)))
        else $error("last read gray changed more than one bit");

    // write gray pointer matches its binary counter
    a_wgray_code: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wgray_ff == (wbin_ff ^ (wbin_ff >> 1)))
        else $error("write gray out of step with counter");

    // read gray pointer matches its binary counter
    a_rgray_code: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rgray_ff == (rbin_ff ^ (rbin_ff >> 1)))
        else $error("read gray out of step with counter");

    // next write pointer is one ahead in gray
    a_wnext_code: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wnext_ff == (wbin_inc ^ (wbin_inc >> 1)))
        else $error("next write gray wrong");

    // next read pointer is one ahead in gray
    a_rnext_code: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rnext_ff == (rbin_inc ^ (rbin_inc >> 1)))
        else $error("next read gray wrong");

    // last read pointer is one behind in gray
    a_rlast_code: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rlast_ff == (rbin_dec ^ (rbin_dec >> 1)))
        else $error("last read gray wrong");

    // an accepted write moves the counter by exactly one
    a_write_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        write_allow |=> (wbin_ff == fifo_pkg::ptr_type'($past(wbin_ff) + 1'b1)))
        else $error("write counter did not step by one");

    // an accepted read moves the counter by exactly one
    a_read_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        read_allow |=> (rbin_ff == fifo_pkg::ptr_type'($past(rbin_ff) + 1'b1)))
        else $error("read counter did not step by one");

    // no accepted write, no pointer movement
    a_write_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !write_allow |=> $stable(wbin_ff) && $stable(wgray_ff))
        else $error("write pointer moved without a write");

    // no accepted read, no pointer movement
    a_read_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !read_allow |=> $stable(rbin_ff) && $stable(rnext_ff))
        else $error("read pointer moved without a read");

    // reset keeps both sides locked out
    a_reset_flags: assert property (@(posedge clock_i)
        !nrst_i |=> empty_ff && full_ff)
        else $error("flags not both high in reset");

    // full rises with the final write, not a tick later
    a_full_early: assert property (@(posedge clock_i) disable iff (!nrst_i)
        write_allow && (wbin_inc2 == rbin_ff) |=> full_ff)
        else $error("full late after final write");

    // level only moves on a write tick
    a_level_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !wr_tick |=> $stable(level_ff))
        else $error("level changed off the write tick");

    // read word stands until the next accepted read
    a_data_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !read_allow |=> $stable(rd_data_o))
        else $error("read word changed without a read");

    // a refused write is logged as an overflow
    a_overflow_log: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_tick && wen_s3_ff && full_ff |=> status_ff[`EV_OVERFLOW])
        else $error("refused write not logged");
endmodule : dual_clock_fifo

/* File: link_agent.sv */
// writer and reader model driving the fifo's two link clocks and request lines
`timescale 1ns/100ps
module link_agent (
    input  wire logic               clock_i,
    input  wire fifo_pkg::word_type rd_data_i,
    output logic                    wr_clk_o,
    output logic                    wr_en_o,
    output fifo_pkg::word_type      wr_data_o,
    output logic                    rd_clk_o,
    output logic                    rd_en_o
);
    // quiet request lines at time zero
    initial begin
        wr_clk_o  = 1'b0;
        rd_clk_o  = 1'b0;
        wr_en_o   = 1'b0;
        rd_en_o   = 1'b0;
        wr_data_o = 36'h0_0000_0000;
    end

    // free-running 48 ns link clocks, offsets chosen so no edge meets clock_i
    initial #2.1 forever #24 wr_clk_o = ~wr_clk_o;
    initial #7.3 forever #24 rd_clk_o = ~rd_clk_o;

    // one write slot: set up in the low half, taken at the next rise
    task automatic push(input fifo_pkg::word_type word, input logic en);
        @(negedge wr_clk_o);
        repeat (2) @(posedge clock_i);
        wr_en_o   <= en;
        wr_data_o <= en ? word : ~wr_data_o; // idle data keeps toggling, never a stale word
        @(posedge wr_clk_o);
    endtask : push

    // one read slot; word is what the previous slot's read presented
    task automatic pull(input logic en, output fifo_pkg::word_type word);
        @(negedge rd_clk_o);
        word    = rd_data_i;
        repeat (2) @(posedge clock_i);
        rd_en_o <= en;
        @(posedge rd_clk_o);
    endtask : pull
endmodule : link_agent

/* File: dual_clock_fifo_test.sv */
// self-checking bench for the sampled-clock fifo with its link model
`timescale 1ns/100ps
`include "fifo_defines.svh"
module dual_clock_fifo_test;
    logic               clock_i = 1'b0;          // system clock
    logic               nrst_i  = 1'b0;          // reset, active low
    logic               wr_clk, wr_en, rd_clk, rd_en, wr_full, rd_empty, irq;
    fifo_pkg::word_type wr_data, rd_data, word;  // link words
    fifo_pkg::word_type expq[$];                 // words in flight, oldest first
    logic [3:0]         fill_level;
    logic [7:0]         reg_addr  = 8'h00;
    logic [31:0]        reg_wdata = 32'h0000_0000;
    logic [31:0]        reg_rdata;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    int                 num_errors = 0;
    int                 compares   = 0;
    int                 cycles     = 0;

    always #2.5 clock_i = ~clock_i;

    dual_clock_fifo i_dual_clock_fifo (
        .clock_i(clock_i), .nrst_i(nrst_i), .wr_clk_i(wr_clk), .wr_en_i(wr_en),
        .wr_data_i(wr_data), .wr_full_o(wr_full), .rd_clk_i(rd_clk), .rd_en_i(rd_en),
        .rd_data_o(rd_data), .rd_empty_o(rd_empty), .fill_level_o(fill_level),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));

    link_agent i_link_agent (
        .clock_i(clock_i), .rd_data_i(rd_data), .wr_clk_o(wr_clk), .wr_en_o(wr_en),
        .wr_data_o(wr_data), .rd_clk_o(rd_clk), .rd_en_o(rd_en));

    // compare with case equality so an unknown never matches
    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // hang guard: a full run needs roughly 10000 cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock_i);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clock_i);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clock_i);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clock_i);
        reg_rd   <= 1'b0;
        @(negedge clock_i);
        data = reg_rdata;
        @(negedge clock_i);
        check("read data one cycle", reg_rdata, 32'h0000_0000);
    endtask : reg_read

    // flags cross domains, so allow a bounded wait
    task automatic wait_flags(input logic e, input logic f);
        for (int n = 0; n < 40 && (rd_empty !== e || wr_full !== f); n++) @(negedge clock_i);
    endtask : wait_flags

    task automatic apply_reset();
        logic [31:0] r;
        i_link_agent.push(36'h0_0000_0000, 1'b0);
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (12) @(posedge clock_i);
        check("empty in reset", rd_empty, 1'b1);
        check("full in reset", wr_full, 1'b1);
        nrst_i <= 1'b1;
        repeat (4) i_link_agent.push(36'h0_0000_0000, 1'b0);
        check("empty after reset", rd_empty, 1'b1);
        check("full after reset", wr_full, 1'b0);
        check("level after reset", fill_level, 4'h0);
        reg_read(`REG_STATUS, r);
        check("status reset", r, 32'h0000_0000);
        expq.delete();
    endtask : apply_reset

    task automatic single_word();
        fifo_pkg::word_type got;
        i_link_agent.push(36'h9_A5A5_0001, 1'b1);
        i_link_agent.push(36'h0_0000_0000, 1'b0);
        wait_flags(1'b0, 1'b0);
        check("empty after write", rd_empty, 1'b0);
        i_link_agent.pull(1'b1, got);
        i_link_agent.pull(1'b0, got);
        check("single word", got, 36'h9_A5A5_0001);
        check("empty on last read", rd_empty, 1'b1);
    endtask : single_word

    task automatic fill_full();
        logic [31:0] r;
        reg_write(`REG_MASK, 32'h0000_0001);
        reg_write(`REG_STATUS, 32'h0000_000F);
        for (int i = 0; i < 511; i++) begin
            if (i == 256) begin
                repeat (2) i_link_agent.push(36'h0_0000_0000, 1'b0);
                check("level at half", fill_level, 4'h8);
            end
            if (i == 510) begin
                i_link_agent.push(36'h0_0000_0000, 1'b0);
                check("full at 510", wr_full, 1'b0);
            end
            word = {4'h3, 32'(i)};
            expq.push_back(word);
            i_link_agent.push(word, 1'b1);
        end
        i_link_agent.push(36'h0_0000_0000, 1'b0);
        check("full on last write", wr_full, 1'b1);
        i_link_agent.push(36'h7_7777_7777, 1'b1);
        i_link_agent.push(36'h0_0000_0000, 1'b0);
        check("level at full", fill_level, 4'hF);
        check("irq on overflow", irq, 1'b1);
        reg_read(`REG_STATUS, r);
        check("overflow event", r[1:0], 2'b01);
        reg_write(`REG_STATE, 32'h0000_0000);
        reg_read(`REG_STATE, r);
        check("state register", r, 32'h0000_00F2);
        reg_read(8'h0C, r);
        check("unmapped read", r, 32'h0000_0000);
        reg_read(`REG_MASK, r);
        check("mask readback", r, 32'h0000_0001);
        reg_write(`REG_STATUS, 32'h0000_0001);
        reg_read(`REG_STATUS, r);
        check("irq cleared", irq, 1'b0);
    endtask : fill_full

    task automatic drain_all();
        fifo_pkg::word_type got;
        logic [31:0]        r;
        i_link_agent.pull(1'b1, got);
        i_link_agent.pull(1'b0, got);
        check("first out", got, expq.pop_front());
        wait_flags(1'b0, 1'b0);
        check("full cleared by read", wr_full, 1'b0);
        for (int i = 0; i < 511; i++) begin
            i_link_agent.pull(i < 510, got);
            if (i > 0) check("fifo order", got, expq.pop_front());
        end
        check("empty after drain", rd_empty, 1'b1);
        i_link_agent.pull(1'b1, got);
        i_link_agent.pull(1'b0, got);
        check("data kept on underflow", got, word);
        reg_read(`REG_STATUS, r);
        check("underflow event", r[1], 1'b1);
        repeat (3) i_link_agent.push(36'h0_0000_0000, 1'b0);
        check("level after drain", fill_level, 4'h0);
    endtask : drain_all

    // main sequence, with a reset in mid-run while words are stored
    initial begin
        apply_reset();
        single_word();
        fill_full();
        drain_all();
        repeat (3) i_link_agent.push(36'h1_0000_0001, 1'b1);
        apply_reset();
        single_word();
        summarize();
    end
endmodule : dual_clock_fifo_test
